//--- ifm_core_model.sv
// Core-side partner: takes a pending interrupt after a set delay.
// Assumes the same clock as the block; take is launched by NBA at the edge.
`timescale 1ns/1ps

module ifm_core_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic irq_pending_in,
    input wire logic auto_in,
    input wire logic [3:0] delay_in,
    output logic irq_take_out
);
    logic [3:0] cnt;

    // One-cycle take; no second take while the first is still in flight
    always @(posedge clk_in)
    begin
        irq_take_out <= 1'b0;
        cnt <= 4'h0;
        if (nrst_in && auto_in && irq_pending_in && !irq_take_out)
        begin
            if (cnt == delay_in)
                irq_take_out <= 1'b1;
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule

//--- ifm_ctrl.sv
// Interrupt request flags, masks, global enable and pin-function
// select for a small 4-bit controller core.
// Assumes the core issues single-bit reads and writes on words 0 to 2,
// nibble writes on the pin-function word, and same-clock pulses for
// timer overflow, stop entry, return and take.
`timescale 1ns/1ps
`include "ifm_map.svh"

module ifm_ctrl #(
    parameter bit HAS_EXT1 = 1'b1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [9:0] reg_addr_in,
    input wire logic [1:0] bit_sel_in,
    input wire logic bit_wr_in,
    input wire logic bit_wdata_in,
    input wire logic nib_wr_in,
    input wire logic [3:0] nib_wdata_in,
    input wire logic ext_irq0_pin_in,
    input wire logic ext_irq1_pin_in,
    input wire logic timer_a_ovf_in,
    input wire logic timer_b_ovf_in,
    input wire logic timer_c_ovf_in,
    input wire logic stop_entry_in,
    input wire logic return_from_interrupt_in,
    input wire logic irq_take_in,
    output logic bit_rdata_out,
    output logic irq_pending_out,
    output logic [4:0] irq_source_out,
    output logic irq_accepted_out,
    output logic global_irq_enable_out,
    output logic ext0_route_out,
    output logic ext1_route_out,
    output logic timer_event_route_out,
    output logic stop_clear_route_out
);

    // ----------------------------------------------------------------
    // Positions of each source's flag and mask in the bit view
    // ----------------------------------------------------------------
    localparam logic [3:0] FLAG_POS [`IFM_NSRC] = '{
        `IFM_POS_F0, `IFM_POS_F1, `IFM_POS_FTA, `IFM_POS_FTB, `IFM_POS_FTC
    };
    localparam logic [3:0] MASK_POS [`IFM_NSRC] = '{
        `IFM_POS_M0, `IFM_POS_M1, `IFM_POS_MTA, `IFM_POS_MTB, `IFM_POS_MTC
    };
    localparam logic [`IFM_NSRC-1:0] SRC_PRESENT =
        HAS_EXT1 ? 5'h1F : 5'h1D;

    ifm_pkg::ifm_state_t st;
    ifm_pkg::ifm_state_t next_st;

    logic [11:0] view;
    logic [11:0] wr_hit;
    logic [3:0] wr_idx;
    logic ctrl_word;
    logic pfs_wr;
    logic [1:0] fall;
    logic [`IFM_NSRC-1:0] hw_set;
    logic [`IFM_NSRC-1:0] sw_clr;
    logic [`IFM_NSRC-1:0] qual;
    logic [`IFM_NSRC-1:0] pick;
    logic accept;

    // ----------------------------------------------------------------
    // Bit view of control words 0 to 2, as the core reads them
    // ----------------------------------------------------------------
    always_comb
    begin
        view = 12'h000;
        view[`IFM_POS_EN] = st.irq_en;
        for (int i = 0; i < `IFM_NSRC; i++)
        begin
            view[FLAG_POS[i]] = st.flag[i] & SRC_PRESENT[i];
            view[MASK_POS[i]] = st.mask[i] & SRC_PRESENT[i];
        end
    end

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    assign ctrl_word = (reg_addr_in == `IFM_ADDR_CTRL0)
        || (reg_addr_in == `IFM_ADDR_CTRL1)
        || (reg_addr_in == `IFM_ADDR_CTRL2);
    assign wr_idx = {reg_addr_in[1:0], bit_sel_in};
    assign pfs_wr = nib_wr_in && (reg_addr_in == `IFM_ADDR_PFS);

    always_comb
    begin
        wr_hit = 12'h000;
        if (bit_wr_in && ctrl_word)
        begin
            wr_hit[wr_idx] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    // Edge comparison uses the second stage and the stage after it,
    // never the first synchroniser stage.
    assign fall[0] = st.prev[0] && !st.sync_b[0]
        && st.route[`IFM_RT_EXT0];
    assign fall[1] = st.prev[1] && !st.sync_b[1]
        && st.route[`IFM_RT_EXT1] && HAS_EXT1;

    assign hw_set = {timer_c_ovf_in, timer_b_ovf_in, timer_a_ovf_in,
        fall} & SRC_PRESENT;

    // Only a written 0 clears; a written 1 has no effect.
    always_comb
    begin
        for (int i = 0; i < `IFM_NSRC; i++)
        begin
            sw_clr[i] = wr_hit[FLAG_POS[i]] && !bit_wdata_in;
        end
    end

    // ----------------------------------------------------------------
    // Qualification and fixed priority
    // ----------------------------------------------------------------
    assign qual = st.flag & ~st.mask & SRC_PRESENT;

    always_comb
    begin
        pick = 5'h00;
        for (int i = `IFM_NSRC - 1; i >= 0; i--)
        begin
            if (qual[i])
            begin
                pick = 5'h00;
                pick[i] = 1'b1;
            end
        end
    end

    // The core takes at its instruction boundary; a take with nothing
    // pending or with the enable low is simply ignored.
    assign accept = irq_take_in && st.irq_en && (qual != 5'h00);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.sync_a = {ext_irq1_pin_in, ext_irq0_pin_in};
        next_st.sync_b = st.sync_a;
        next_st.prev = st.sync_b;
        next_st.accepted = accept;
        if (accept)
        begin
            next_st.source = pick;
        end

        // Write priority: stop, then accept, then return, then bit write
        if (wr_hit[`IFM_POS_EN])
        begin
            next_st.irq_en = bit_wdata_in;
        end
        if (return_from_interrupt_in)
        begin
            next_st.irq_en = 1'b1;
        end
        if (accept)
        begin
            next_st.irq_en = 1'b0;
        end

        for (int i = 0; i < `IFM_NSRC; i++)
        begin
            // Acceptance is not a clear term here on purpose
            next_st.flag[i] = (st.flag[i] && !sw_clr[i])
                || hw_set[i];
            if (wr_hit[MASK_POS[i]] && SRC_PRESENT[i])
            begin
                next_st.mask[i] = bit_wdata_in;
            end
        end

        if (pfs_wr)
        begin
            next_st.route = nib_wdata_in;
            if (!HAS_EXT1)
            begin
                next_st.route[`IFM_RT_EXT1] = 1'b0;
            end
        end

        if (stop_entry_in)
        begin
            next_st.irq_en = 1'b0;
            next_st.flag = `IFM_RST_FLAG;
            next_st.mask = `IFM_RST_MASK;
            next_st.route[`IFM_RT_EXT0] = 1'b0;
            next_st.route[`IFM_RT_EXT1] = 1'b0;
            // Stop-clear route and timer event route are left alone
        end

        next_st.pending = next_st.irq_en
            && ((next_st.flag & ~next_st.mask & SRC_PRESENT) != 5'h00);
        next_st.rd_data = ctrl_word ? view[wr_idx] : 1'b0;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            st.sync_a <= `IFM_RST_SYNC;
            st.sync_b <= `IFM_RST_SYNC;
            st.prev <= `IFM_RST_SYNC;
            st.irq_en <= `IFM_RST_EN;
            st.flag <= `IFM_RST_FLAG;
            st.mask <= `IFM_RST_MASK;
            st.route <= `IFM_RST_ROUTE;
            st.rd_data <= 1'b0;
            st.pending <= 1'b0;
            st.source <= 5'h00;
            st.accepted <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign bit_rdata_out = st.rd_data;
    assign irq_pending_out = st.pending;
    assign irq_source_out = st.source;
    assign irq_accepted_out = st.accepted;
    assign global_irq_enable_out = st.irq_en;
    assign ext0_route_out = st.route[`IFM_RT_EXT0];
    assign ext1_route_out = st.route[`IFM_RT_EXT1];
    assign timer_event_route_out = st.route[`IFM_RT_TMB];
    assign stop_clear_route_out = st.route[`IFM_RT_STOP_CLR];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_pin0_fall;
        (ext0_route_out && ext_irq0_pin_in && !stop_entry_in)
        ##1 (ext0_route_out && !ext_irq0_pin_in && !stop_entry_in
            && !bit_wr_in && !pfs_wr) [*4];
    endsequence

    sequence s_take_ok;
        irq_take_in && st.irq_en && (qual != 5'h00) && !stop_entry_in;
    endsequence

    chk_clear_route_keep: assert property (
        stop_entry_in && !pfs_wr
        |=> stop_clear_route_out == $past(stop_clear_route_out)
            && timer_event_route_out == $past(timer_event_route_out))
        else $error("stop-clear route changed on stop entry");

    chk_ext_route_stop: assert property (
        stop_entry_in |=> !ext0_route_out && !ext1_route_out)
        else $error("interrupt routes not cleared by stop");

    chk_stop_masks: assert property (
        stop_entry_in |=> st.mask == `IFM_RST_MASK && st.flag == `IFM_RST_FLAG && !st.irq_en)
        else $error("stop did not force masks, flags and enable");

    chk_enable_on_accept: assert property (
        s_take_ok |=> !global_irq_enable_out && irq_accepted_out)
        else $error("enable not cleared on accept");

    chk_accept_gated: assert property (
        irq_accepted_out |-> $past(st.irq_en)
            && (($past(qual) & irq_source_out) != 5'h00))
        else $error("accepted without enable or qualified source");

    chk_enable_return: assert property (
        return_from_interrupt_in && !irq_take_in && !stop_entry_in
        |=> global_irq_enable_out)
        else $error("return did not set enable");

    chk_priority_pick: assert property (
        irq_accepted_out |-> $onehot(irq_source_out)
            && ((($past(qual) & (irq_source_out - 5'h01)) == 5'h00)))
        else $error("lower priority source won");

    chk_flag_rise: assert property (
        $rose(st.flag[0]) |-> $past(fall[0]))
        else $error("ext0 flag set without falling edge");

    chk_write_one: assert property (
        wr_hit[`IFM_POS_FTB] && bit_wdata_in && !timer_b_ovf_in
            && !stop_entry_in
        |=> st.flag[3] == $past(st.flag[3]))
        else $error("write of one changed a flag");

    chk_masked_hold: assert property (
        st.flag[2] && st.mask[2] && !stop_entry_in
            && !wr_hit[`IFM_POS_FTA]
        |=> st.flag[2])
        else $error("pending request lost");

    chk_set_wins: assert property (
        timer_c_ovf_in && wr_hit[`IFM_POS_FTC] && !bit_wdata_in
            && !stop_entry_in
        |=> st.flag[4])
        else $error("clear beat a same-cycle set");

    chk_pin_edge: assert property (
        s_pin0_fall |-> ##[0:2] st.flag[0])
        else $error("synchronised falling edge not flagged");

    chk_no_ext1: assert property (
        !HAS_EXT1 |-> !st.flag[1] && !ext1_route_out)
        else $error("absent second input became active");

    chk_route_write: assert property (
        pfs_wr && !stop_entry_in
        |=> stop_clear_route_out == $past(nib_wdata_in[`IFM_RT_STOP_CLR])
            && timer_event_route_out == $past(nib_wdata_in[`IFM_RT_TMB]))
        else $error("route bits did not follow the select write");

    chk_no_accept_off: assert property (
        !global_irq_enable_out |=> !irq_accepted_out)
        else $error("accepted while enable was low");

    chk_enable_write: assert property (
        wr_hit[`IFM_POS_EN] && !return_from_interrupt_in && !accept
            && !stop_entry_in
        |=> global_irq_enable_out == $past(bit_wdata_in))
        else $error("enable bit write did not land");

    chk_timer_set: assert property (
        timer_a_ovf_in && !stop_entry_in |=> st.flag[2])
        else $error("timer overflow did not set its flag");

    chk_flag_clear: assert property (
        wr_hit[`IFM_POS_FTC] && !bit_wdata_in && !timer_c_ovf_in
            && !stop_entry_in
        |=> !st.flag[4])
        else $error("write of zero did not clear the flag");

    chk_keep_on_accept: assert property (
        accept && st.flag[0] && !sw_clr[0] && !stop_entry_in
        |=> st.flag[0])
        else $error("acceptance cleared a request flag");

endmodule

//--- ifm_ctrl_test.sv
// Self-checking bench for the interrupt flag, mask and pin-function block.
// Assumes ifm_ctrl, ifm_core_model and ifm_map.svh are compiled alongside.
`timescale 1ns/1ps
`include "ifm_map.svh"

module ifm_ctrl_test;
    localparam logic [11:0] RST_BITS = 12'hAA8;
    logic clk_in, nrst_in, bit_wr_in, bit_wdata_in, nib_wr_in, auto_take;
    logic [9:0] reg_addr_in;
    logic [1:0] bit_sel_in, pins;
    logic [3:0] nib_wdata_in, take_dly;
    logic [4:0] ev, irq_source_out;
    logic bit_rdata_out, irq_pending_out, irq_accepted_out, global_irq_enable_out;
    logic ext0_route_out, ext1_route_out, timer_event_route_out, stop_clear_route_out;
    logic lt_rd, lt_r1;
    wire irq_take_in;
    wire ext_irq0_pin_in = pins[0];
    wire ext_irq1_pin_in = pins[1];
    wire timer_a_ovf_in = ev[4];
    wire timer_b_ovf_in = ev[3];
    wire timer_c_ovf_in = ev[2];
    wire stop_entry_in = ev[1];
    wire return_from_interrupt_in = ev[0];
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int i;

    ifm_ctrl u_ifm_ctrl (.clk_in, .nrst_in, .reg_addr_in, .bit_sel_in, .bit_wr_in,
        .bit_wdata_in, .nib_wr_in, .nib_wdata_in, .ext_irq0_pin_in, .ext_irq1_pin_in,
        .timer_a_ovf_in, .timer_b_ovf_in, .timer_c_ovf_in, .stop_entry_in,
        .return_from_interrupt_in, .irq_take_in, .bit_rdata_out, .irq_pending_out,
        .irq_source_out, .irq_accepted_out, .global_irq_enable_out, .ext0_route_out,
        .ext1_route_out, .timer_event_route_out, .stop_clear_route_out);

    // Reduced variant shares all stimulus except take, which is tied low; only its second-input view is checked
    ifm_ctrl #(.HAS_EXT1(1'b0)) u_ifm_ctrl_lite (.clk_in, .nrst_in, .reg_addr_in,
        .bit_sel_in, .bit_wr_in, .bit_wdata_in, .nib_wr_in, .nib_wdata_in,
        .ext_irq0_pin_in, .ext_irq1_pin_in, .timer_a_ovf_in, .timer_b_ovf_in,
        .timer_c_ovf_in, .stop_entry_in, .return_from_interrupt_in, .irq_take_in(1'b0),
        .bit_rdata_out(lt_rd), .irq_pending_out(), .irq_source_out(),
        .irq_accepted_out(), .global_irq_enable_out(), .ext0_route_out(),
        .ext1_route_out(lt_r1), .timer_event_route_out(), .stop_clear_route_out());

    ifm_core_model u_ifm_core_model (.clk_in, .nrst_in, .irq_pending_in(irq_pending_out),
        .auto_in(auto_take), .delay_in(take_dly), .irq_take_out(irq_take_in));

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [1:0] s, input logic e);
        @(posedge clk_in);
        #1 reg_addr_in = a;
        bit_sel_in = s;
        @(posedge clk_in);
        #1 chk(bit_rdata_out, e);
    endtask

    task automatic wr(input logic [9:0] a, input logic [1:0] s, input logic d);
        @(posedge clk_in);
        #1 reg_addr_in = a;
        bit_sel_in = s;
        bit_wdata_in = d;
        bit_wr_in = 1'b1;
        @(posedge clk_in);
        #1 bit_wr_in = 1'b0;
    endtask

    task automatic nib(input logic [3:0] d);
        @(posedge clk_in);
        #1 reg_addr_in = `IFM_ADDR_PFS;
        nib_wdata_in = d;
        nib_wr_in = 1'b1;
        @(posedge clk_in);
        #1 nib_wr_in = 1'b0;
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge clk_in);
        #1 ev = v;
        @(posedge clk_in);
        #1 ev = 5'h00;
    endtask

    // Five edges cover the two sync stages and the compare
    task automatic pin(input int n, input logic v);
        @(posedge clk_in);
        #1 pins[n] = v;
        repeat (5) @(posedge clk_in);
    endtask

    task automatic wait_acc(input logic [4:0] src);
        for (int k = 0; k < 20 && irq_accepted_out !== 1'b1; k++)
        begin
            @(posedge clk_in);
            #1;
        end
        chk(irq_accepted_out, 1'b1);
        chk(irq_source_out, src);
        chk(global_irq_enable_out, 1'b0);
    endtask

    task automatic stop_test();
        $display("Checks: %0d, mismatches: %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            $display("ERROR at %0t: run did not finish", $time);
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        {nrst_in, bit_wr_in, bit_wdata_in, nib_wr_in, auto_take} = 5'h00;
        reg_addr_in = 10'h000;
        bit_sel_in = 2'h0;
        nib_wdata_in = 4'h0;
        take_dly = 4'h0;
        ev = 5'h00;
        pins = 2'h3;
        repeat (5) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        for (i = 0; i < 12; i++)
            rd(10'(i / 4), 2'(i % 4), RST_BITS[i]);
        chk({stop_clear_route_out, timer_event_route_out, ext1_route_out,
             ext0_route_out}, 4'h0);
        for (i = 1; i < 6; i++)
        begin
            wr(10'((2 * i + 1) / 4), 2'((2 * i + 1) % 4), 1'b0);
            rd(10'((2 * i + 1) / 4), 2'((2 * i + 1) % 4), 1'b0);
            wr(10'(i / 2), 2'((2 * i) % 4), 1'b1);
            rd(10'(i / 2), 2'((2 * i) % 4), 1'b0);
        end
        wr(10'h000, 2'h1, 1'b1);
        rd(10'h000, 2'h1, 1'b0);
        rd(10'h003, 2'h0, 1'b0);
        pulse(5'h1C);
        rd(10'h001, 2'h2, 1'b1);
        rd(10'h002, 2'h0, 1'b1);
        rd(10'h002, 2'h2, 1'b1);
        chk(irq_pending_out, 1'b0);
        auto_take = 1'b1;
        wr(10'h000, 2'h0, 1'b1);
        wait_acc(5'h04);
        rd(10'h001, 2'h2, 1'b1);
        wr(10'h001, 2'h2, 1'b0);
        take_dly = 4'h3;
        pulse(5'h01);
        chk(global_irq_enable_out, 1'b1);
        wait_acc(5'h08);
        wr(10'h002, 2'h0, 1'b0);
        wr(10'h002, 2'h3, 1'b1);
        pulse(5'h01);
        repeat (8) @(posedge clk_in);
        #1 chk(irq_pending_out, 1'b0);
        wr(10'h002, 2'h3, 1'b0);
        wait_acc(5'h10);
        wr(10'h002, 2'h2, 1'b0);
        fork
            wr(10'h002, 2'h0, 1'b0);
            pulse(5'h08);
        join
        rd(10'h002, 2'h0, 1'b1);
        wr(10'h002, 2'h0, 1'b0);
        auto_take = 1'b0;
        pin(0, 1'b0);
        rd(10'h000, 2'h2, 1'b0);
        pin(0, 1'b1);
        nib(4'h3);
        chk({ext1_route_out, ext0_route_out}, 2'h3);
        chk(lt_r1, 1'b0);
        pin(0, 1'b0);
        rd(10'h000, 2'h2, 1'b1);
        wr(10'h000, 2'h2, 1'b0);
        pin(0, 1'b1);
        rd(10'h000, 2'h2, 1'b0);
        pin(0, 1'b0);
        pin(1, 1'b0);
        rd(10'h001, 2'h0, 1'b1);
        chk(lt_rd, 1'b0);
        pulse(5'h1C);
        auto_take = 1'b1;
        wr(10'h000, 2'h0, 1'b1);
        wait_acc(5'h01);
        rd(10'h000, 2'h2, 1'b1);
        wr(10'h000, 2'h2, 1'b0);
        pulse(5'h01);
        wait_acc(5'h02);
        auto_take = 1'b0;
        nib(4'hF);
        wr(10'h000, 2'h0, 1'b1);
        pulse(5'h02);
        chk({stop_clear_route_out, timer_event_route_out, ext1_route_out,
             ext0_route_out}, 4'hC);
        for (i = 0; i < 12; i++)
            rd(10'(i / 4), 2'(i % 4), RST_BITS[i]);
        stop_test();
    end
endmodule

//--- ifm_map.svh
// Address, bit position and reset constants for the interrupt flag,
// mask and pin-function block.
// Assumes word addresses are 10 bits and control words are 4 bits wide.
`ifndef IFM_MAP_SVH
`define IFM_MAP_SVH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define IFM_ADDR_CTRL0 10'h000
`define IFM_ADDR_CTRL1 10'h001
`define IFM_ADDR_CTRL2 10'h002
`define IFM_ADDR_PFS 10'h024

// ----------------------------------------------------------------
// Bit positions in the 12-bit view of words 0 to 2
// ----------------------------------------------------------------
`define IFM_POS_EN 4'h0
`define IFM_POS_RSP 4'h1
`define IFM_POS_F0 4'h2
`define IFM_POS_M0 4'h3
`define IFM_POS_F1 4'h4
`define IFM_POS_M1 4'h5
`define IFM_POS_FTA 4'h6
`define IFM_POS_MTA 4'h7
`define IFM_POS_FTB 4'h8
`define IFM_POS_MTB 4'h9
`define IFM_POS_FTC 4'hA
`define IFM_POS_MTC 4'hB

// ----------------------------------------------------------------
// Route bits and reset values
// ----------------------------------------------------------------
`define IFM_RT_EXT0 2'h0
`define IFM_RT_EXT1 2'h1
`define IFM_RT_TMB 2'h2
`define IFM_RT_STOP_CLR 2'h3
`define IFM_NSRC 5
`define IFM_RST_FLAG 5'h00
`define IFM_RST_MASK 5'h1F
`define IFM_RST_ROUTE 4'h0
`define IFM_RST_EN 1'h0
// Synchronisers idle high, like the pins, so release makes no false edge
`define IFM_RST_SYNC 2'h3

`endif

//--- ifm_pkg.sv
// Types shared by the interrupt flag, mask and pin-function block.
// Assumes ifm_map.svh is on the include path.
`include "ifm_map.svh"

package ifm_pkg;

    // Source order is also priority order: 0 is highest
    typedef struct packed {
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic [1:0] prev;
        logic irq_en;
        logic [`IFM_NSRC-1:0] flag;
        logic [`IFM_NSRC-1:0] mask;
        logic [3:0] route;
        logic rd_data;
        logic pending;
        logic [`IFM_NSRC-1:0] source;
        logic accepted;
    } ifm_state_t;

endpackage
